// [rtl/fjv_core.sv]
// Frequency command shaping, jump bands and V/F voltage reference.
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module fjv_core import fjv_pkg::*; (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_HSEL,
    input wire logic [AW-1:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic [FW-1:0] I_FREQ_CMD,
    input wire logic I_START,
    input wire logic I_JOG,
    input wire logic I_RAMPING,
    input wire logic [FW-1:0] I_RAMP_FREQ,
    input wire logic I_STALL_ACTIVE,
    input wire logic [FW-1:0] I_STALL_FREQ,
    input wire logic I_REVERSE,
    input wire logic [NTERM-1:0] I_TERM,
    input wire logic [FW-1:0] I_SUPPLY_VOLT,
    input wire logic I_SINGLE_100V,
    input wire logic I_FLUX_VECTOR,
    output logic [FW-1:0] O_FREQ_TARGET,
    output logic [FW-1:0] O_RUN_FREQ,
    output logic [FW-1:0] O_VOLT_REF,
    output logic [FW-1:0] O_ACTIVE_BASE_FREQ,
    output logic [FW-1:0] O_SCURVE_BEND,
    output logic O_SCURVE_EN,
    output logic O_SECOND_FUNC,
    output logic O_BOOST_ZERO
);
    // ==========================================================
    // Helpers and state
    function automatic logic [FW-1:0] fmin(input logic [FW-1:0] a, b);
        fmin = (a < b) ? a : b;
    endfunction
    function automatic logic band_on(input logic [FW-1:0] a, b);
        band_on = (a != CODE_OFF) && (b != CODE_OFF);
    endfunction
    // The band is closed at both ends, whichever of A and B is lower.
    function automatic logic in_band(input logic [FW-1:0] f,
                                     input logic [FW-1:0] a, b);
        in_band = band_on(a, b) && (f >= fmin(a, b))
            && (f <= ((a < b) ? b : a));
    endfunction
    typedef struct packed {
        logic [NCFG-1:0][FW-1:0] cfg;
        logic [NTERM-1:0][7:0] tsel;
        logic ph_we;
        logic [AW-1:0] ph_addr;
        logic [31:0] rdata;
        logic ready;
        logic [FW-1:0] tgt;
        logic [FW-1:0] run;
        logic [FW-1:0] vref;
        logic [FW-1:0] abase;
        logic [FW-1:0] bend;
        logic scurve;
        logic sfunc;
        logic bzero;
        fjv_vs_e vs;
        logic [FW-1:0] vf;
        logic [FW-1:0] vb10;
        logic sq;
        logic go;
        logic [31:0] num;
        logic [FW-1:0] den;
    } fjv_main_s;
    fjv_main_s st_ff;
    fjv_main_s nxt_st;
    logic div_done;
    logic [31:0] div_quo;
    logic [FW-1:0] cmd_sel;
    logic [FW-1:0] capped;
    logic [FW-1:0] clamped;
    logic [FW-1:0] jumped;
    logic jog_bypass;
    logic no_bands;
    logic sfunc_now;
    logic [16:0] supply_eff;
    logic [31:0] supply95;
    logic [FW-1:0] vbase;
    logic [19:0] vb10_wide;
    logic [FW-1:0] fb_now;
    logic addr_ok;
    logic [FW-1:0] rd_idx;
    logic [31:0] rd_val;
    // ==========================================================
    // Frequency path, base values and register read mux
    always_comb begin
        cmd_sel = I_JOG ? st_ff.cfg[CFG_JOG] : I_FREQ_CMD;
        capped = fmin(cmd_sel, st_ff.cfg[CFG_MAX]);
        jog_bypass = I_JOG && (st_ff.cfg[CFG_JOG] <= st_ff.cfg[CFG_MIN]);
        clamped = capped;
        if (!I_START) begin
            clamped = '0;
        end else if (!jog_bypass && (capped < st_ff.cfg[CFG_MIN])
            && ((capped != '0)
            || (st_ff.cfg[CFG_MIN] >= st_ff.cfg[CFG_STARTF]))) begin
            clamped = st_ff.cfg[CFG_MIN];
        end
        jumped = clamped;
        no_bands = 1'b1;
        for (int k = 2; k >= 0; k--) begin
            if (band_on(st_ff.cfg[CFG_J1A + 2*k],
                        st_ff.cfg[CFG_J1A + 2*k + 1])) begin
                no_bands = 1'b0;
            end
            if (in_band(clamped, st_ff.cfg[CFG_J1A + 2*k],
                        st_ff.cfg[CFG_J1A + 2*k + 1])) begin
                jumped = st_ff.cfg[CFG_J1A + 2*k];
            end
        end
    end
    always_comb begin
        sfunc_now = 1'b0;
        for (int t = 0; t < NTERM; t++) begin
            if (st_ff.tsel[t] == TSEL_SECOND && I_TERM[t]) begin
                sfunc_now = 1'b1;
            end
        end
        supply_eff = I_SINGLE_100V ? {I_SUPPLY_VOLT, 1'b0}
            : {1'b0, I_SUPPLY_VOLT};
        supply95 = ({15'h0000, supply_eff} * PCT_95) / PCT_ALL;
        if (I_FLUX_VECTOR) begin
            fb_now = st_ff.cfg[CFG_RATEDF];
            vbase = st_ff.cfg[CFG_RATEDV];
        end else begin
            fb_now = (sfunc_now && st_ff.cfg[CFG_SBASEF] != CODE_OFF)
                ? st_ff.cfg[CFG_SBASEF] : st_ff.cfg[CFG_BASEF];
            if (st_ff.cfg[CFG_BASEV] == CODE_OFF) begin
                vbase = supply_eff[16] ? LIM_V16 : supply_eff[15:0];
            end else if (st_ff.cfg[CFG_BASEV] == CODE_95PCT) begin
                vbase = supply95[15:0];
            end else if ({1'b0, st_ff.cfg[CFG_BASEV]} < supply_eff) begin
                vbase = st_ff.cfg[CFG_BASEV];
            end else begin
                vbase = supply_eff[16] ? LIM_V16 : supply_eff[15:0];
            end
        end
        // Saturating the tenth-volt scale keeps the divider at 32 bits.
        vb10_wide = {4'h0, vbase} * VOLT_X10;
        vb10_wide = (vb10_wide > {4'h0, LIM_V16}) ? {4'h0, LIM_V16}
            : vb10_wide;
    end
    always_comb begin
        addr_ok = 1'b1;
        rd_idx = {10'h000, I_HADDR[AW-1:2]};
        rd_val = '0;
        if (I_HADDR[1:0] != 2'h0) begin
            addr_ok = 1'b0;
        end else if (rd_idx < 16'(NCFG)) begin
            rd_val = {16'h0000, st_ff.cfg[rd_idx]};
        end else if (I_HADDR == OFS_TSEL_LO) begin
            rd_val = st_ff.tsel[3:0];
        end else if (I_HADDR == OFS_TSEL_HI) begin
            rd_val = {8'h00, st_ff.tsel[6:4]};
        end else if (I_HADDR == OFS_STATUS) begin
            rd_val = {27'h0000000, st_ff.vs != VS_IDLE, st_ff.scurve,
                      st_ff.bzero, st_ff.sfunc, I_START};
        end else if (I_HADDR == OFS_RUN) begin
            rd_val = {16'h0000, st_ff.run};
        end else if (I_HADDR == OFS_VREF) begin
            rd_val = {16'h0000, st_ff.vref};
        end else begin
            addr_ok = 1'b0;
        end
        // A write still in its data phase is forwarded to the next read.
        if (st_ff.ph_we && st_ff.ph_addr == I_HADDR) begin
            if (rd_idx < 16'(NCFG)) begin
                rd_val = {16'h0000, I_HWDATA[15:0]};
            end else if (I_HADDR == OFS_TSEL_LO) begin
                rd_val = I_HWDATA;
            end else if (I_HADDR == OFS_TSEL_HI) begin
                rd_val = {8'h00, I_HWDATA[23:0]};
            end
        end
    end
    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.go = 1'b0;
        nxt_st.ready = 1'b1;
        // Bus data phase, then a new address phase.
        nxt_st.ph_we = 1'b0;
        if (st_ff.ph_we) begin
            if ({10'h000, st_ff.ph_addr[AW-1:2]} < 16'(NCFG)) begin
                nxt_st.cfg[st_ff.ph_addr[AW-1:2]] = I_HWDATA[15:0];
            end else if (st_ff.ph_addr == OFS_TSEL_LO) begin
                nxt_st.tsel[3:0] = I_HWDATA;
            end else if (st_ff.ph_addr == OFS_TSEL_HI) begin
                nxt_st.tsel[6:4] = I_HWDATA[23:0];
            end
        end
        if (I_HSEL && I_HREADY && I_HTRANS[1]) begin
            nxt_st.ph_addr = I_HADDR;
            nxt_st.ph_we = I_HWRITE && addr_ok && (I_HSIZE == HSIZE_WORD);
            nxt_st.rdata = I_HWRITE ? 32'h00000000 : rd_val;
        end
        // Frequency outputs.
        nxt_st.tgt = jumped;
        if (I_STALL_ACTIVE) begin
            nxt_st.run = I_STALL_FREQ;
        end else if (I_RAMPING) begin
            nxt_st.run = I_RAMP_FREQ;
        end else begin
            nxt_st.run = jumped;
        end
        nxt_st.sfunc = sfunc_now;
        nxt_st.abase = fb_now;
        nxt_st.scurve = (st_ff.cfg[CFG_ACCPAT] == ACC_S_CURVE_A);
        nxt_st.bend = nxt_st.scurve ? fb_now : '0;
        nxt_st.bzero = !I_FLUX_VECTOR
            && (((st_ff.cfg[CFG_LOADPAT][1:0] == PAT_LIFT_FWD) && I_REVERSE)
            || ((st_ff.cfg[CFG_LOADPAT][1:0] == PAT_LIFT_REV)
            && !I_REVERSE));
        // Voltage sequencer: none, one or two divisions per update.
        case (st_ff.vs)
            VS_IDLE: begin
                nxt_st.vf = st_ff.run;
                nxt_st.vb10 = vb10_wide[15:0];
                nxt_st.sq = !I_FLUX_VECTOR
                    && (st_ff.cfg[CFG_LOADPAT] == {14'h0000, PAT_SQUARE});
                if (fb_now == '0 || st_ff.run >= fb_now) begin
                    nxt_st.vref = vb10_wide[15:0];
                end else begin
                    nxt_st.num = vb10_wide[15:0] * st_ff.run;
                    nxt_st.den = fb_now;
                    nxt_st.go = 1'b1;
                    nxt_st.vs = VS_DIV1;
                end
            end
            VS_DIV1: begin
                if (div_done) begin
                    if (st_ff.sq) begin
                        nxt_st.num = div_quo[15:0] * st_ff.vf;
                        nxt_st.go = 1'b1;
                        nxt_st.vs = VS_DIV2;
                    end else begin
                        nxt_st.vref = div_quo[15:0];
                        nxt_st.vs = VS_IDLE;
                    end
                end
            end
            VS_DIV2: begin
                if (div_done) begin
                    nxt_st.vref = div_quo[15:0];
                    nxt_st.vs = VS_IDLE;
                end
            end
            default: begin
                nxt_st.vs = VS_IDLE;
            end
        endcase
    end
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            st_ff <= '0;
            st_ff.cfg <= CFG_RST;
            st_ff.vs <= VS_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end
    fjv_div u_div (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_start(st_ff.go),
        .i_num(st_ff.num),
        .i_den(st_ff.den),
        .o_done(div_done),
        .o_quo(div_quo)
    );
    assign O_HRDATA = st_ff.rdata;
    assign O_HREADYOUT = st_ff.ready;
    assign O_HRESP = 1'b0;
    assign O_FREQ_TARGET = st_ff.tgt;
    assign O_RUN_FREQ = st_ff.run;
    assign O_VOLT_REF = st_ff.vref;
    assign O_ACTIVE_BASE_FREQ = st_ff.abase;
    assign O_SCURVE_BEND = st_ff.bend;
    assign O_SCURVE_EN = st_ff.scurve;
    assign O_SECOND_FUNC = st_ff.sfunc;
    assign O_BOOST_ZERO = st_ff.bzero;
    // ==========================================================
    // Assertions
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    a_max_clamp: assert property (I_START && !I_JOG && no_bands
        && I_FREQ_CMD > st_ff.cfg[CFG_MAX]
        && st_ff.cfg[CFG_MAX] >= st_ff.cfg[CFG_MIN] && !st_ff.ph_we
        |=> O_FREQ_TARGET == $past(st_ff.cfg[CFG_MAX]))
        else $error("Command above maximum not clamped.");
    a_min_clamp: assert property (I_START && !I_JOG && no_bands
        && I_FREQ_CMD != '0 && I_FREQ_CMD < st_ff.cfg[CFG_MIN]
        && st_ff.cfg[CFG_MIN] <= st_ff.cfg[CFG_MAX] && !st_ff.ph_we
        |=> O_FREQ_TARGET == $past(st_ff.cfg[CFG_MIN]))
        else $error("Command below minimum not clamped.");
    a_jog_bypass: assert property (I_START && I_JOG && no_bands
        && st_ff.cfg[CFG_JOG] <= st_ff.cfg[CFG_MIN]
        && st_ff.cfg[CFG_JOG] <= st_ff.cfg[CFG_MAX] && !st_ff.ph_we
        |=> O_FREQ_TARGET == $past(st_ff.cfg[CFG_JOG]))
        else $error("Jog frequency overridden by minimum.");
    a_start_alone: assert property (I_START && !I_JOG && no_bands
        && I_FREQ_CMD == '0 && st_ff.cfg[CFG_MIN] >= st_ff.cfg[CFG_STARTF]
        && st_ff.cfg[CFG_MIN] <= st_ff.cfg[CFG_MAX] && !st_ff.ph_we
        |=> O_FREQ_TARGET == $past(st_ff.cfg[CFG_MIN]))
        else $error("Start alone did not target minimum.");
    a_stall_pass: assert property (I_STALL_ACTIVE
        |=> O_RUN_FREQ == $past(I_STALL_FREQ))
        else $error("Stall frequency not passed to output.");
    a_ramp_pass: assert property (I_RAMPING && !I_STALL_ACTIVE
        |=> O_RUN_FREQ == $past(I_RAMP_FREQ))
        else $error("Ramp frequency altered by jump band.");
    a_jump_hold: assert property (!I_RAMPING && !I_STALL_ACTIVE
        && in_band(clamped, st_ff.cfg[CFG_J1A], st_ff.cfg[CFG_J1A + 1])
        |=> O_RUN_FREQ == $past(st_ff.cfg[CFG_J1A]))
        else $error("Steady frequency inside band one not held at A.");
    a_boost_zero: assert property (!I_FLUX_VECTOR && I_REVERSE
        && st_ff.cfg[CFG_LOADPAT] == {14'h0000, PAT_LIFT_FWD}
        |=> O_BOOST_ZERO)
        else $error("Boost not forced to zero in reverse.");
    a_second_base: assert property (!I_FLUX_VECTOR && sfunc_now
        && st_ff.cfg[CFG_SBASEF] != CODE_OFF && !st_ff.ph_we
        |=> O_ACTIVE_BASE_FREQ == $past(st_ff.cfg[CFG_SBASEF]))
        else $error("Second base frequency not selected.");
    a_flux_base: assert property (I_FLUX_VECTOR && !st_ff.ph_we
        |=> O_ACTIVE_BASE_FREQ == $past(st_ff.cfg[CFG_RATEDF]))
        else $error("Flux vector mode not using rated frequency.");
    a_volt_hold: assert property (st_ff.vs == VS_IDLE
        && fb_now != '0 && st_ff.run >= fb_now
        |=> O_VOLT_REF == $past(vb10_wide[15:0]))
        else $error("Voltage not held above base frequency.");
    a_volt_bound: assert property (st_ff.vs == VS_DIV1
        ##0 div_done && !st_ff.sq |=> O_VOLT_REF <= $past(st_ff.vb10))
        else $error("Linear voltage exceeds base voltage.");
    c_jump_hit: cover property (!I_RAMPING && jumped != clamped);
    c_square_done: cover property (st_ff.vs == VS_DIV2 && div_done);
    c_second_func: cover property (sfunc_now && !I_FLUX_VECTOR);
    c_stall_low: cover property (I_STALL_ACTIVE
        && I_STALL_FREQ < st_ff.cfg[CFG_MIN]);
endmodule

// [rtl/fjv_div.sv]
// Sequential unsigned divider used by the voltage characteristic.
`timescale 1ns/10ps
module fjv_div import fjv_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [31:0] i_num,
    input wire logic [FW-1:0] i_den,
    output logic o_done,
    output logic [31:0] o_quo
);

    // ==========================================================
    // State
    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] cnt;
        logic [32:0] rem;
        logic [31:0] quo;
    } fjv_div_s;

    fjv_div_s st_ff;
    fjv_div_s nxt_st;
    logic [32:0] trial;

    // ==========================================================
    // Restoring division, one quotient bit per cycle.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        trial = {st_ff.rem[31:0], st_ff.quo[31]};
        if (i_start && !st_ff.busy) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt = 6'(DIV_STEPS);
            nxt_st.rem = '0;
            nxt_st.quo = i_num;
        end else if (st_ff.busy) begin
            nxt_st.quo = {st_ff.quo[30:0], 1'b0};
            if (trial >= {17'h00000, i_den}) begin
                nxt_st.rem = trial - {17'h00000, i_den};
                nxt_st.quo[0] = 1'b1;
            end else begin
                nxt_st.rem = trial;
            end
            nxt_st.cnt = st_ff.cnt - 6'h01;
            if (st_ff.cnt == 6'h01) begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_done = st_ff.done;
    assign o_quo = st_ff.quo;

endmodule

// [rtl/fjv_pkg.sv]
// Constants, register map and types of the frequency shaping and V/F block.
package fjv_pkg;

    // ==========================================================
    // Widths and encodings
    localparam int FW = 16;
    localparam int AW = 8;
    localparam int NTERM = 7;
    localparam int DIV_STEPS = 32;
    localparam logic [FW-1:0] CODE_OFF = 16'h270F;
    localparam logic [FW-1:0] CODE_95PCT = 16'h22B8;
    localparam logic [31:0] PCT_95 = 32'h0000005F;
    localparam logic [31:0] PCT_ALL = 32'h00000064;
    localparam logic [19:0] VOLT_X10 = 20'h0000A;
    localparam logic [FW-1:0] LIM_V16 = 16'hFFFF;
    localparam logic [1:0] PAT_LINEAR = 2'h0;
    localparam logic [1:0] PAT_SQUARE = 2'h1;
    localparam logic [1:0] PAT_LIFT_FWD = 2'h2;
    localparam logic [1:0] PAT_LIFT_REV = 2'h3;
    localparam logic [FW-1:0] ACC_S_CURVE_A = 16'h0001;
    localparam logic [7:0] TSEL_SECOND = 8'h03;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ==========================================================
    // Configuration words, index times four is the byte offset
    localparam int CFG_MAX = 0;
    localparam int CFG_MIN = 1;
    localparam int CFG_STARTF = 2;
    localparam int CFG_JOG = 3;
    localparam int CFG_J1A = 4;
    localparam int CFG_BASEF = 10;
    localparam int CFG_BASEV = 11;
    localparam int CFG_SBASEF = 12;
    localparam int CFG_LOADPAT = 13;
    localparam int CFG_ACCPAT = 14;
    localparam int CFG_RATEDV = 15;
    localparam int CFG_RATEDF = 16;
    localparam int NCFG = 17;
    localparam logic [AW-1:0] OFS_TSEL_LO = 8'h44;
    localparam logic [AW-1:0] OFS_TSEL_HI = 8'h48;
    localparam logic [AW-1:0] OFS_STATUS = 8'h4C;
    localparam logic [AW-1:0] OFS_RUN = 8'h50;
    localparam logic [AW-1:0] OFS_VREF = 8'h54;

    // Frequencies in 0.1 Hz, voltages in 1 V.
    localparam logic [NCFG-1:0][FW-1:0] CFG_RST = {
        16'h0258, 16'h00C8, 16'h0000, 16'h0000, 16'h270F, 16'h270F,
        16'h0258, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F,
        16'h270F, 16'h0032, 16'h0005, 16'h0000, 16'h04B0};

    // ==========================================================
    // Voltage sequencer states
    typedef enum logic [2:0] {
        VS_IDLE = 3'h1,
        VS_DIV1 = 3'h2,
        VS_DIV2 = 3'h4
    } fjv_vs_e;

endpackage

// [verification/fjv_drive_model.sv]
// Behavioural model of the drive ramp and stall side.
`timescale 1ns/10ps
module fjv_drive_model import fjv_pkg::*; (
    input wire logic i_clk,
    input wire logic i_ramp_go,
    input wire logic i_stall_go,
    input wire logic [FW-1:0] i_ramp_to,
    input wire logic [FW-1:0] i_stall_to,
    output logic o_ramping,
    output logic [FW-1:0] o_ramp_freq,
    output logic o_stall,
    output logic [FW-1:0] o_stall_freq
);
    // ======================================================
    // Ramp and stall outputs
    // A frequency whose flag is low is not valid, so it toggles every
    // cycle; a design that reads it anyway shows a wrong value at once.
    initial begin
        o_ramping = 1'b0;
        o_stall = 1'b0;
        o_ramp_freq = 16'h0000;
        o_stall_freq = 16'h0000;
    end
    always @(posedge i_clk) begin
        o_ramping <= i_ramp_go;
        o_stall <= i_stall_go;
        o_ramp_freq <= i_ramp_go ? i_ramp_to : ~o_ramp_freq;
        o_stall_freq <= i_stall_go ? i_stall_to : ~o_stall_freq;
    end
endmodule

// [verification/freq_jump_and_vf_curve_tb.sv]
// Self-checking testbench of the frequency shaping and V/F block.
`timescale 1ns/10ps
module freq_jump_and_vf_curve_tb import fjv_pkg::*;;
    logic clk = 0, rst = 1, hsel = 0, hwr = 0, hrdy, hresp;
    logic [AW-1:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic [FW-1:0] cmd = 16'h0, supply = 16'h00C8, rto = 16'h0, sto = 16'h0;
    logic start = 0, jog = 0, rev = 0, s100 = 0, flux = 0, rgo = 0, sgo = 0;
    logic [NTERM-1:0] term = 7'h00;
    logic ramping, stall, sen, sfunc, bzero;
    logic [FW-1:0] rfreq, sfreq, tgt, run, vref, abase, bend;
    int n_fail = 0, check_count = 0, cyc = 0;
    fjv_drive_model PM (.i_clk(clk), .i_ramp_go(rgo), .i_stall_go(sgo),
        .i_ramp_to(rto), .i_stall_to(sto), .o_ramping(ramping),
        .o_ramp_freq(rfreq), .o_stall(stall), .o_stall_freq(sfreq));
    fjv_core DUT (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwr),
        .I_HSIZE(HSIZE_WORD), .I_HWDATA(hwdata), .I_HREADY(hrdy),
        .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
        .I_FREQ_CMD(cmd), .I_START(start), .I_JOG(jog), .I_RAMPING(ramping),
        .I_RAMP_FREQ(rfreq), .I_STALL_ACTIVE(stall), .I_STALL_FREQ(sfreq),
        .I_REVERSE(rev), .I_TERM(term), .I_SUPPLY_VOLT(supply),
        .I_SINGLE_100V(s100), .I_FLUX_VECTOR(flux), .O_FREQ_TARGET(tgt),
        .O_RUN_FREQ(run), .O_VOLT_REF(vref), .O_ACTIVE_BASE_FREQ(abase),
        .O_SCURVE_BEND(bend), .O_SCURVE_EN(sen), .O_SECOND_FUNC(sfunc),
        .O_BOOST_ZERO(bzero));
    // ======================================================
    // Clock, timeout and shared tasks
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // The master waits for hready without assuming a latency.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwr <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk("register", e, q);
        chk("hresp", 32'h0, hresp);
    endtask
    task automatic st(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ======================================================
    // Scenarios
    task automatic t_regs();
        rd(8'h28, 32'h00000258);
        rd(8'h2C, 32'h0000270F);
        rd(8'h80, 32'h00000000);
    endtask
    task automatic t_clamp();
        wr(8'h04, 32'h64);
        start <= 1'b1;
        cmd <= 16'h07D0;
        st(3); chk("target", 32'h04B0, tgt);
        cmd <= 16'h0032;
        st(3); chk("target", 32'h0064, tgt);
        cmd <= 16'h0000;
        st(3); chk("target", 32'h0064, tgt);
        jog <= 1'b1;
        st(3); chk("target", 32'h0032, tgt);
        jog <= 1'b0;
        sgo <= 1'b1;
        sto <= 16'h0014;
        st(4); chk("run", 32'h0014, run);
        sgo <= 1'b0;
        wr(8'h04, 32'h0);
    endtask
    task automatic t_jump();
        wr(8'h10, 32'h12C);
        wr(8'h14, 32'h15E);
        wr(8'h18, 32'h1C2);
        wr(8'h1C, 32'h190);
        wr(8'h24, 32'h1F4);
        cmd <= 16'h0140;
        st(3); chk("target", 32'h012C, tgt);
        cmd <= 16'h01A4;
        st(3); chk("target", 32'h01C2, tgt);
        cmd <= 16'h015E;
        st(3); chk("target", 32'h012C, tgt);
        cmd <= 16'h0208;
        st(3); chk("target", 32'h0208, tgt);
        rgo <= 1'b1;
        rto <= 16'h014A;
        st(4); chk("run", 32'h014A, run);
        rgo <= 1'b0;
    endtask
    task automatic t_volt();
        wr(8'h2C, 32'hC8);
        cmd <= 16'h012C;
        st(200); chk("vref", 32'h03E8, vref);
        cmd <= 16'h0384;
        st(200); chk("vref", 32'h07D0, vref);
        wr(8'h34, 32'h1);
        cmd <= 16'h012C;
        st(200); chk("vref", 32'h01F4, vref);
        wr(8'h34, 32'h0);
        wr(8'h2C, 32'h96);
        cmd <= 16'h0258;
        st(200); chk("vref", 32'h05DC, vref);
        wr(8'h2C, 32'h22B8);
        st(200); chk("vref", 32'h076C, vref);
        wr(8'h2C, 32'h270F);
        s100 <= 1'b1;
        supply <= 16'h0064;
        st(200); chk("vref", 32'h07D0, vref);
        s100 <= 1'b0;
        supply <= 16'h00C8;
    endtask
    task automatic t_base();
        term <= 7'h01;
        st(4); chk("second", 32'h0, sfunc);
        wr(8'h44, 32'h3);
        rd(8'h44, 32'h00000003);
        st(4); chk("second", 32'h1, sfunc);
        chk("base", 32'h0258, abase);
        wr(8'h30, 32'h12C);
        wr(8'h38, 32'h1);
        st(4); chk("base", 32'h012C, abase);
        chk("bend", 32'h012C, bend);
        chk("scurve", 32'h1, sen);
        flux <= 1'b1;
        wr(8'h40, 32'h1F4);
        st(4); chk("base", 32'h01F4, abase);
        flux <= 1'b0;
        term <= 7'h00;
    endtask
    task automatic t_boost();
        for (int k = 0; k < 8; k++) begin
            wr(8'h34, k / 2);
            rev <= k[0];
            st(4); chk("boost", (k == 5) || (k == 6), bzero);
        end
    endtask
    initial begin
        st(20);
        rst <= 1'b0;
        st(2);
        t_regs();
        t_clamp();
        t_jump();
        t_volt();
        t_base();
        t_boost();
        summarize();
    end
endmodule
